// file: pfpm_pkg.sv
// shared types and constants for the pin function priority mux
package pfpm_pkg;

    // one shared pin as seen from the mux: output value and low-true enable
    typedef struct packed {
        logic out;
        logic oe_n;
    } pfpm_drv_type;

    // analog connections of the upper analog port pins
    typedef struct packed {
        logic amp_inv;
        logic an8;
        logic an9;
    } pfpm_analog_type;

    // synchroniser width and bit positions of the pin inputs
    localparam int unsigned PFPM_SYNC_W    = 7;
    localparam int unsigned PFPM_IDX_DBG   = 0;
    localparam int unsigned PFPM_IDX_PE0   = 1;
    localparam int unsigned PFPM_IDX_PE1   = 2;
    localparam int unsigned PFPM_IDX_PAD8  = 3;
    localparam int unsigned PFPM_IDX_PAD9  = 4;
    localparam int unsigned PFPM_IDX_PAD5  = 5;
    localparam int unsigned PFPM_IDX_IOC3  = 6;
    localparam logic [6:0]  PFPM_SYNC_RST  = 7'h00;

    // trigger route field layout and source codes
    localparam int unsigned PFPM_TRIG_W        = 3;
    localparam int unsigned PFPM_TRIG_SRC_LSB  = 0;
    localparam int unsigned PFPM_TRIG_EDGE_BIT = 2;
    localparam logic [1:0]  PFPM_TRIG_TIMER    = 2'h0;
    localparam logic [1:0]  PFPM_TRIG_ACMP     = 2'h1;
    localparam logic [1:0]  PFPM_TRIG_PE0      = 2'h2;
    localparam logic [1:0]  PFPM_TRIG_PAD5     = 2'h3;

    // capture channel three input routing codes
    localparam logic [1:0]  PFPM_IC3_PIN       = 2'h0;
    localparam logic [1:0]  PFPM_IC3_RX0       = 2'h1;
    localparam logic [1:0]  PFPM_IC3_RX1       = 2'h2;

    // reset values and boot strap settle count
    localparam logic [1:0]  PFPM_DRV_RST       = 2'h1;
    // settle covers three sync flops plus the agreement register
    localparam logic [2:0]  PFPM_BOOT_SETTLE   = 3'h4;
    localparam logic [2:0]  PFPM_BOOT_CNT_RST  = 3'h0;

endpackage

// file: pfpm_sync3.sv
// three-stage pin input synchroniser with agreement filter
module pfpm_sync3
    import pfpm_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   resetn_i,
    // raw pins and filtered result
    input  wire logic [PFPM_SYNC_W-1:0] pin_i,
    output logic      [PFPM_SYNC_W-1:0] sync_o
);

    logic [PFPM_SYNC_W-1:0] s1_r;
    logic [PFPM_SYNC_W-1:0] s2_r;
    logic [PFPM_SYNC_W-1:0] s3_r;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    for (genvar b = 0; b < PFPM_SYNC_W; b++) begin : g_bit
        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                s1_r[b]   <= PFPM_SYNC_RST[b];
                s2_r[b]   <= PFPM_SYNC_RST[b];
                s3_r[b]   <= PFPM_SYNC_RST[b];
                sync_o[b] <= PFPM_SYNC_RST[b];
            end else begin
                s1_r[b] <= pin_i[b];
                s2_r[b] <= s1_r[b];
                s3_r[b] <= s2_r[b];
                if (s2_r[b] == s3_r[b]) begin
                    sync_o[b] <= s3_r[b];
                end
            end
        end
    end

endmodule

// file: pfpm_mux.sv
// pin function priority mux for debug pin, port E and upper port AD
//////////////////////////////////////////////////////////////////////////////
module pfpm_mux
    import pfpm_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   resetn_i,
    // single wire debug pin
    input  wire logic                   dbg_pin_i,
    input  wire logic                   dbg_tx_i,
    input  wire logic                   dbg_tx_en_i,
    output pfpm_drv_type                single_wire_debug_pin_o,
    output logic                        dbg_rx_o,
    output logic                        boot_mode_select_input_o,
    output logic                        dbg_active_o,
    // oscillator port E
    input  wire logic [1:0]             pe_pin_i,
    input  wire logic                   osc_en_i,
    input  wire logic [1:0]             pe_data_i,
    input  wire logic [1:0]             pe_dir_i,
    output pfpm_drv_type                oscillator_output_pin_o,
    output pfpm_drv_type                oscillator_input_pin_o,
    output logic      [1:0]             oscillator_port_data_bit_o,
    // upper analog port pins, index 0 is the lower pin
    input  wire logic [1:0]             pad_pin_i,
    input  wire logic [1:0]             adc_en_i,
    input  wire logic                   amp_en_i,
    input  wire logic [1:0]             pad_data_i,
    input  wire logic [1:0]             pad_dir_i,
    output pfpm_drv_type [1:0]          ad_pin_o,
    output pfpm_analog_type             analog_conn_o,
    output logic      [1:0]             analog_port_high_data_bit_o,
    output logic      [1:0]             analog_port_high_wakeup_o,
    // converter trigger routing
    input  wire logic                   pad5_pin_i,
    input  wire logic [PFPM_TRIG_W-1:0] trigger_source_route_field_i,
    input  wire logic                   timer_oc_link_i,
    input  wire logic                   acmp_out_i,
    output logic                        converter_external_trigger_o,
    // capture channel three routing
    input  wire logic                   ioc3_pin_i,
    input  wire logic [1:0]             ic3_route_i,
    input  wire logic                   serial_receive_zero_i,
    input  wire logic                   serial_receive_one_i,
    output logic                        timer_capture_channel_three_o
);

    logic [PFPM_SYNC_W-1:0] pin_raw;
    logic [PFPM_SYNC_W-1:0] pin_q;
    logic [2:0]             boot_cnt_r;
    logic                   boot_done_r;
    logic [1:0]             trig_src;
    logic                   trig_sel;
    logic                   trig_pe0_sel;
    logic                   ic3_sel;

    //////////////////////////////////////////////////////////////////////////
    // pin input synchronisers
    assign pin_raw = {ioc3_pin_i, pad5_pin_i, pad_pin_i[1], pad_pin_i[0],
                      pe_pin_i[1], pe_pin_i[0], dbg_pin_i};

    pfpm_sync3 u_sync (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pin_i     (pin_raw),
        .sync_o    (pin_q)
    );

    //////////////////////////////////////////////////////////////////////////
    // boot strap: let the synchroniser fill, then catch the pin once
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            boot_cnt_r               <= PFPM_BOOT_CNT_RST;
            boot_done_r              <= 1'b0;
            boot_mode_select_input_o <= 1'b0;
        end else if (!boot_done_r) begin
            if (boot_cnt_r == PFPM_BOOT_SETTLE) begin
                boot_done_r              <= 1'b1;
                boot_mode_select_input_o <= pin_q[PFPM_IDX_DBG];
            end else begin
                boot_cnt_r <= boot_cnt_r + 3'h1;
            end
        end
    end

    // debug wire: input only until the strap is caught, then two-way
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            single_wire_debug_pin_o <= PFPM_DRV_RST;
            dbg_rx_o                <= 1'b1;
            dbg_active_o            <= 1'b0;
        end else begin
            dbg_active_o                 <= boot_done_r;
            dbg_rx_o                     <= boot_done_r ?
                pin_q[PFPM_IDX_DBG] : 1'b1; // no false edge while settling
            single_wire_debug_pin_o.out  <= dbg_tx_i;
            single_wire_debug_pin_o.oe_n <= !(boot_done_r && dbg_tx_en_i);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // trigger and capture source selection, same-clock sources unsynchronised
    assign trig_src     = trigger_source_route_field_i[PFPM_TRIG_SRC_LSB +: 2];
    assign trig_pe0_sel = (trig_src == PFPM_TRIG_PE0);

    always_comb begin
        trig_sel = timer_oc_link_i;
        if (trig_src == PFPM_TRIG_ACMP) begin
            trig_sel = acmp_out_i;
        end else if (trig_src == PFPM_TRIG_PE0) begin
            trig_sel = pin_q[PFPM_IDX_PE0];
        end else if (trig_src == PFPM_TRIG_PAD5) begin
            trig_sel = pin_q[PFPM_IDX_PAD5];
        end
    end

    always_comb begin
        ic3_sel = pin_q[PFPM_IDX_IOC3];
        if (ic3_route_i == PFPM_IC3_RX0) begin
            ic3_sel = serial_receive_zero_i;
        end else if (ic3_route_i == PFPM_IC3_RX1) begin
            ic3_sel = serial_receive_one_i;
        end
    end

    // edge select inverts the level so the converter always sees rising
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            converter_external_trigger_o  <= 1'b0;
            timer_capture_channel_three_o <= 1'b0;
        end else begin
            converter_external_trigger_o  <= trig_sel ^
                trigger_source_route_field_i[PFPM_TRIG_EDGE_BIT];
            timer_capture_channel_three_o <= ic3_sel;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // port E: oscillator, then routed trigger (input pin only), then general port
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oscillator_output_pin_o    <= PFPM_DRV_RST;
            oscillator_input_pin_o     <= PFPM_DRV_RST;
            oscillator_port_data_bit_o <= 2'h0;
        end else begin
            // read value is broadcast even while a function owns the pin
            oscillator_port_data_bit_o <= {pin_q[PFPM_IDX_PE1],
                                           pin_q[PFPM_IDX_PE0]};
            oscillator_output_pin_o.out  <= pe_data_i[1];
            oscillator_output_pin_o.oe_n <= osc_en_i || !pe_dir_i[1];
            oscillator_input_pin_o.out   <= pe_data_i[0];
            oscillator_input_pin_o.oe_n  <= osc_en_i || trig_pe0_sel ||
                                            !pe_dir_i[0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // upper analog port: amplifier (lower pin only), converter, port bit
    for (genvar p = 0; p < 2; p++) begin : g_pad
        logic analog_own;
        assign analog_own = adc_en_i[p] || ((p == 0) && amp_en_i);

        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                ad_pin_o[p]                    <= PFPM_DRV_RST;
                analog_port_high_data_bit_o[p] <= 1'b0;
                analog_port_high_wakeup_o[p]   <= 1'b0;
            end else begin
                ad_pin_o[p].out  <= pad_data_i[p];
                ad_pin_o[p].oe_n <= analog_own || !pad_dir_i[p];
                analog_port_high_data_bit_o[p] <= pin_q[PFPM_IDX_PAD8 + p];
                analog_port_high_wakeup_o[p]   <=
                    pin_q[PFPM_IDX_PAD8 + p];
            end
        end
    end

    // analog switch selection on the two upper pins
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            analog_conn_o <= '0;
        end else begin
            analog_conn_o.amp_inv <= amp_en_i;
            analog_conn_o.an8     <= adc_en_i[0] && !amp_en_i;
            analog_conn_o.an9     <= adc_en_i[1];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_boot_wait;
        !boot_done_r ##1 boot_done_r;
    endsequence

    property p_boot_latch;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        s_boot_wait |-> boot_mode_select_input_o == $past(pin_q[PFPM_IDX_DBG]);
    endproperty
    a_boot_latch: assert property (p_boot_latch)
        else $error("boot mode not caught from debug pin");

    property p_dbg_quiet;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !boot_done_r |=> single_wire_debug_pin_o.oe_n;
    endproperty
    a_dbg_quiet: assert property (p_dbg_quiet)
        else $error("debug pin driven before strap capture");

    property p_osc_own;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        osc_en_i |=> oscillator_output_pin_o.oe_n &&
                     oscillator_input_pin_o.oe_n;
    endproperty
    a_osc_own: assert property (p_osc_own)
        else $error("port E driven while oscillator enabled");

    property p_trig_pe0;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (!osc_en_i && trig_pe0_sel && pe_dir_i[0]) |=>
            oscillator_input_pin_o.oe_n;
    endproperty
    a_trig_pe0: assert property (p_trig_pe0)
        else $error("general port beat routed trigger");

    property p_pe_gpio;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (!osc_en_i && pe_dir_i[1]) |=> !oscillator_output_pin_o.oe_n &&
            oscillator_output_pin_o.out == $past(pe_data_i[1]);
    endproperty
    a_pe_gpio: assert property (p_pe_gpio)
        else $error("port E not following general port");

    property p_adc_own;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        adc_en_i[1] |=> ad_pin_o[1].oe_n && analog_conn_o.an9;
    endproperty
    a_adc_own: assert property (p_adc_own)
        else $error("converter input lost to port bit");

    property p_amp_own;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        amp_en_i |=> ad_pin_o[0].oe_n && analog_conn_o.amp_inv &&
                     !analog_conn_o.an8;
    endproperty
    a_amp_own: assert property (p_amp_own)
        else $error("amplifier input not on top");

    property p_bcast;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        analog_port_high_wakeup_o == analog_port_high_data_bit_o;
    endproperty
    a_bcast: assert property (p_bcast)
        else $error("wakeup and port read disagree");

    property p_trig_route;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (trig_src == PFPM_TRIG_ACMP) |=> converter_external_trigger_o ==
            ($past(acmp_out_i) ^
             $past(trigger_source_route_field_i[PFPM_TRIG_EDGE_BIT]));
    endproperty
    a_trig_route: assert property (p_trig_route)
        else $error("comparator trigger route wrong");

    property p_ic3_rx1;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (ic3_route_i == PFPM_IC3_RX1) |=>
            timer_capture_channel_three_o == $past(serial_receive_one_i);
    endproperty
    a_ic3_rx1: assert property (p_ic3_rx1)
        else $error("capture input not on second receive line");

endmodule

// file: pfpm_pin_model.sv
// far side of the shared pins: board levels behind the mux drives
module pfpm_pin_model
    import pfpm_pkg::*;
(
    // drives coming out of the mux, oe_n low while it drives
    input  wire pfpm_drv_type       dbg_drv_i,
    input  wire pfpm_drv_type [1:0] pe_drv_i,
    input  wire pfpm_drv_type [1:0] ad_drv_i,
    // levels the board shows once the mux lets go
    input  wire logic               dbg_ext_i,
    input  wire logic [1:0]         pe_ext_i,
    input  wire logic [1:0]         ad_ext_i,
    // resolved pin levels back into the mux
    output logic                    dbg_pin_o,
    output logic [1:0]              pe_pin_o,
    output logic [1:0]              ad_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    //////////////////////////////////////////////////////////////////////
    // no pulls modelled: a released pin shows the board value, which the
    // bench changes every test, so a stale drive never reads back by luck
    always_comb begin
        dbg_pin_o = dbg_drv_i.oe_n ? dbg_ext_i : dbg_drv_i.out;
        for (int i = 0; i < 2; i++) begin
            pe_pin_o[i] = pe_drv_i[i].oe_n ? pe_ext_i[i] : pe_drv_i[i].out;
            ad_pin_o[i] = ad_drv_i[i].oe_n ? ad_ext_i[i] : ad_drv_i[i].out;
        end
    end
endmodule

// file: pfpm_mux_tb_top.sv
// self-checking bench for the pin function priority mux
module pfpm_mux_tb_top
    import pfpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {int id; logic [3:0] mask; logic [3:0] exp;} pfpm_note_type;

    // design inputs, driven by the bench except the pins from the pin model
    logic clk_sys_i, resetn_i, dbg_tx_i, dbg_tx_en_i, osc_en_i, amp_en_i;
    logic pad5_pin_i, timer_oc_link_i, acmp_out_i, ioc3_pin_i;
    logic serial_receive_zero_i, serial_receive_one_i, dbg_ext;
    logic [1:0] pe_data_i, pe_dir_i, adc_en_i, pad_data_i, pad_dir_i;
    logic [1:0] ic3_route_i, pe_ext, ad_ext;
    logic [2:0] trigger_source_route_field_i;
    wire logic       dbg_pin_i;
    wire logic [1:0] pe_pin_i, pad_pin_i;
    // design outputs
    pfpm_drv_type single_wire_debug_pin_o, oscillator_output_pin_o;
    pfpm_drv_type oscillator_input_pin_o;
    pfpm_drv_type [1:0] ad_pin_o;
    pfpm_analog_type analog_conn_o;
    logic dbg_rx_o, boot_mode_select_input_o, dbg_active_o;
    logic converter_external_trigger_o, timer_capture_channel_three_o;
    logic [1:0] oscillator_port_data_bit_o, analog_port_high_data_bit_o;
    logic [1:0] analog_port_high_wakeup_o;
    // scoreboard state
    pfpm_note_type notes[$];
    pfpm_note_type note_c;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'h25b3_5c98;
    string nm[9] = '{"dbg_drive", "dbg_rx", "strap", "osc_drive",
                     "pe_read", "ad_drive", "analog", "pad_read", "routes"};

    //////////////////////////////////////////////////////////////////////
    pfpm_mux i_pfpm_mux (
        .clk_sys_i, .resetn_i, .dbg_pin_i, .dbg_tx_i, .dbg_tx_en_i,
        .single_wire_debug_pin_o, .dbg_rx_o, .boot_mode_select_input_o,
        .dbg_active_o, .pe_pin_i, .osc_en_i, .pe_data_i, .pe_dir_i,
        .oscillator_output_pin_o, .oscillator_input_pin_o,
        .oscillator_port_data_bit_o, .pad_pin_i, .adc_en_i, .amp_en_i,
        .pad_data_i, .pad_dir_i, .ad_pin_o, .analog_conn_o,
        .analog_port_high_data_bit_o, .analog_port_high_wakeup_o,
        .pad5_pin_i, .trigger_source_route_field_i, .timer_oc_link_i,
        .acmp_out_i, .converter_external_trigger_o, .ioc3_pin_i,
        .ic3_route_i, .serial_receive_zero_i, .serial_receive_one_i,
        .timer_capture_channel_three_o
    );

    pfpm_pin_model i_pfpm_pin_model (
        .dbg_drv_i(single_wire_debug_pin_o),
        .pe_drv_i({oscillator_output_pin_o, oscillator_input_pin_o}),
        .ad_drv_i(ad_pin_o), .dbg_ext_i(dbg_ext), .pe_ext_i(pe_ext),
        .ad_ext_i(ad_ext), .dbg_pin_o(dbg_pin_i), .pe_pin_o(pe_pin_i),
        .ad_pin_o(pad_pin_i)
    );

    //////////////////////////////////////////////////////////////////////
    // clock and hang guard, ceiling far above the roughly 190 cycles used
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end

    //////////////////////////////////////////////////////////////////////
    // output groups packed to 4 bits so one note can name any of them
    function automatic logic [3:0] obs(input int id);
        case (id)
            0: return {2'h0, single_wire_debug_pin_o};
            1: return {3'h0, dbg_rx_o};
            2: return {2'h0, dbg_active_o, boot_mode_select_input_o};
            3: return {oscillator_output_pin_o, oscillator_input_pin_o};
            4: return {2'h0, oscillator_port_data_bit_o};
            5: return ad_pin_o;
            6: return {1'b0, analog_conn_o};
            7: return {analog_port_high_data_bit_o,
                       analog_port_high_wakeup_o};
            default: return {2'h0, converter_external_trigger_o,
                             timer_capture_channel_three_o};
        endcase
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    endfunction

    task automatic check(input int id, input logic [3:0] got,
                         input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm[id], exp, got);
        end
    endtask

    task automatic note(input int id, input logic [3:0] m,
                        input logic [3:0] e);
        notes.push_back('{id, m, e});
    endtask

    // watcher: outputs have settled by the falling edge
    always @(negedge clk_sys_i) begin
        while (notes.size() > 0) begin
            note_c = notes.pop_front();
            check(note_c.id, obs(note_c.id) & note_c.mask, note_c.exp);
        end
    end

    //////////////////////////////////////////////////////////////////////
    // mid-run reset with a given strap level, then debug drives the pin
    task automatic strap(input logic lvl);
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        dbg_ext <= lvl;
        dbg_tx_en_i <= 1'b1;
        dbg_tx_i <= ~lvl;
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        note(0, 4'h1, 4'h1);
        note(2, 4'h2, 4'h0);
        repeat (8) @(posedge clk_sys_i);
        note(2, 4'h3, {3'h1, lvl});
        note(0, 4'h3, {2'h0, ~lvl, 1'b0});
        repeat (8) @(posedge clk_sys_i);
        note(1, 4'h1, {3'h0, ~lvl});
        dbg_tx_en_i <= 1'b0;
        $display("test strap %0d done", lvl);
    endtask

    // random pin use; k walks every trigger source and capture route
    task automatic mix_step(input logic [3:0] k);
        logic [31:0] r;
        logic [1:0] dp, da, pl, al;
        logic t, c;
        rnd = lfsr(rnd);
        r = rnd;
        osc_en_i <= r[0];
        {pe_ext, pe_data_i, pe_dir_i} <= r[6:1];
        {amp_en_i, adc_en_i} <= r[9:7];
        {ad_ext, pad_data_i, pad_dir_i} <= r[15:10];
        trigger_source_route_field_i <= {r[16], k[1:0]};
        {ioc3_pin_i, pad5_pin_i, acmp_out_i, timer_oc_link_i} <= r[20:17];
        {serial_receive_one_i, serial_receive_zero_i} <= r[22:21];
        ic3_route_i <= k[3:2];
        dp = {~r[0] & r[2], ~r[0] & r[1] & (k[1:0] != PFPM_TRIG_PE0)};
        da = {~r[8] & r[11], ~r[7] & ~r[9] & r[10]};
        pl = (dp & r[4:3]) | (~dp & r[6:5]);
        al = (da & r[13:12]) | (~da & r[15:14]);
        t = (k[1:0] == 2'h0) ? r[17] : (k[1:0] == 2'h1) ? r[18] :
            (k[1:0] == 2'h2) ? pl[0] : r[19];
        c = (k[3:2] == 2'h1) ? r[21] : (k[3:2] == 2'h2) ? r[22] : r[20];
        repeat (8) @(posedge clk_sys_i);
        note(3, {dp[1], 1'b1, dp[0], 1'b1},
             {dp[1] & r[4], ~dp[1], dp[0] & r[3], ~dp[0]});
        note(5, {da[1], 1'b1, da[0], 1'b1},
             {da[1] & r[13], ~da[1], da[0] & r[12], ~da[0]});
        note(6, 4'h7, {1'b0, r[9], r[7] & ~r[9], r[8]});
        note(4, 4'h3, {2'h0, pl});
        note(7, 4'hf, {al, al});
        note(8, 4'h3, {2'h0, t ^ r[16], c});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////
    // main sequence: reset state, two straps, then the routing sweep
    initial begin
        {resetn_i, dbg_tx_i, dbg_tx_en_i, osc_en_i, amp_en_i, pad5_pin_i,
         timer_oc_link_i, acmp_out_i, ioc3_pin_i, serial_receive_zero_i,
         serial_receive_one_i, dbg_ext, pe_data_i, pe_dir_i, adc_en_i,
         pad_data_i, pad_dir_i, ic3_route_i, pe_ext, ad_ext,
         trigger_source_route_field_i} = '0;
        repeat (16) @(posedge clk_sys_i);
        note(0, 4'h3, 4'h1);
        note(1, 4'h1, 4'h1);
        note(2, 4'h3, 4'h0);
        note(3, 4'hf, 4'h5);
        note(5, 4'hf, 4'h5);
        note(8, 4'h3, 4'h0);
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        $display("test reset done");
        strap(1'b1);
        strap(1'b0);
        for (int k = 0; k < 16; k++) begin
            mix_step(4'(k));
        end
        $display("test routing done");
        @(negedge clk_sys_i);
        results();
    end
endmodule
